// *** logic/uco_charger_otg_regs.sv ***
// Functional notes
// - control high-impedance bit set puts USB charger into high-impedance mode.
// - boost select zero keeps boost off unless OTG pin requests with pin enable.
// - boost select one runs boost unless high-impedance bit is set.
// - charge-disable bit disables charger; timer expiry sets it regardless of source.
// - float code in bits 7:2, 20 mV steps from 3.5 V, reset 3.54 V.
// - voltage register at address 2 resets to 0x0A; slave address D6.
// - OTG polarity bit 1 selects active-low pin at 0, active-high at 1.
// - OTG pin enable bit 0 lets an active pin start boost.
`timescale 1ns/1ps
`default_nettype none
`include "uco_defines.svh"
module uco_charger_otg_regs
	import uco_pkg::*;
(
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	input  wire logic       I_SCL,
	input  wire logic       I_SDA,
	output var  logic       O_SDA_OUT,
	output var  logic       O_SDA_OE,
	input  wire logic       I_OTG_PIN,
	input  wire logic       I_FIFTEEN_MINUTE_TIMER_EXPIRED,
	output var  logic       O_USB_HIGH_IMPEDANCE,
	output var  logic       O_USB_CHARGE_DISABLE,
	output var  logic       O_BOOST_ENABLE,
	output var  logic [5:0] O_USB_FLOAT_VOLTAGE_CODE
);
	uco_reg_if bus ();

	uco_i2c_slave u_i2c (
		.i_clk    (I_CLK),
		.i_rst    (I_RST),
		.i_scl    (I_SCL),
		.i_sda    (I_SDA),
		.o_sda_oe (O_SDA_OE),
		.bus      (bus.eng)
	);

	// ********************************
	// OTG pin synchroniser
	// ********************************
	logic [2:0] otg_sync_reg, otg_sync_next;
	logic       otg_f_reg, otg_f_next;

	always_comb begin
		otg_sync_next = {otg_sync_reg[1:0], I_OTG_PIN};
		otg_f_next    = (otg_sync_reg[1] == otg_sync_reg[2]) ? otg_sync_reg[2] : otg_f_reg;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			otg_sync_reg <= 3'h0;
			otg_f_reg    <= 1'b0;
		end else begin
			otg_sync_reg <= otg_sync_next;
			otg_f_reg    <= otg_f_next;
		end
	end

	// ********************************
	// registers and derived controls
	// ********************************
	logic       hz_reg, hz_next;
	logic       sel_reg, sel_next;
	logic       cd_reg, cd_next;
	logic [7:0] volt_reg, volt_next;
	logic       boost_reg, boost_next;
	logic [5:0] code_reg, code_next;
	logic       otg_active;
	logic [5:0] code_field;

	assign code_field = volt_reg[`UCO_VOLT_CODE_HI:`UCO_VOLT_CODE_LO];
	// pin level counted as a request per the polarity bit
	assign otg_active = volt_reg[`UCO_VOLT_OTG_POL] ? otg_f_reg : ~otg_f_reg;

	always_comb begin
		hz_next   = hz_reg;
		sel_next  = sel_reg;
		cd_next   = cd_reg;
		volt_next = volt_reg;
		if (bus.wr_stb && bus.addr == `UCO_REG_CTRL) begin
			hz_next  = bus.wdata[`UCO_CTRL_HIGH_Z];
			sel_next = bus.wdata[`UCO_CTRL_BOOST_SEL];
			cd_next  = bus.wdata[`UCO_CTRL_CHG_DIS];
		end else if (bus.wr_stb && bus.addr == `UCO_REG_VOLT) begin
			volt_next = bus.wdata;
		end
		// expiry beats a same-cycle software clear
		if (I_FIFTEEN_MINUTE_TIMER_EXPIRED) begin
			cd_next = 1'b1;
		end
		// high impedance blocks both boost paths
		boost_next = ~hz_reg & (sel_reg | (volt_reg[`UCO_VOLT_OTG_PIN_ENABLE] & otg_active));
		// codes past the top of the scale saturate at 4.44 V
		code_next = (code_field > `UCO_FLOAT_CODE_MAX) ? `UCO_FLOAT_CODE_MAX : code_field;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			hz_reg    <= `UCO_CTRL_RST;
			sel_reg   <= `UCO_CTRL_RST;
			cd_reg    <= `UCO_CTRL_RST;
			volt_reg  <= `UCO_VOLT_RST;
			boost_reg <= 1'b0;
			code_reg  <= 6'(`UCO_VOLT_RST >> `UCO_VOLT_CODE_LO);
		end else begin
			hz_reg    <= hz_next;
			sel_reg   <= sel_next;
			cd_reg    <= cd_next;
			volt_reg  <= volt_next;
			boost_reg <= boost_next;
			code_reg  <= code_next;
		end
	end

	always_comb begin
		if (bus.addr == `UCO_REG_CTRL) begin
			bus.rdata = {5'h00, cd_reg, hz_reg, sel_reg};
		end else if (bus.addr == `UCO_REG_VOLT) begin
			bus.rdata = volt_reg;
		end else begin
			bus.rdata = `UCO_READ_UNMAPPED;
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge I_CLK) begin
		O_SDA_OUT <= 1'b0;
	end

	assign O_USB_HIGH_IMPEDANCE     = hz_reg;
	assign O_USB_CHARGE_DISABLE     = cd_reg;
	assign O_BOOST_ENABLE           = boost_reg;
	assign O_USB_FLOAT_VOLTAGE_CODE = code_reg;

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	property p_hz_write;
		bus.wr_stb && bus.addr == `UCO_REG_CTRL |=> O_USB_HIGH_IMPEDANCE == $past(bus.wdata[`UCO_CTRL_HIGH_Z]);
	endproperty
	a_hz_write: assert property (p_hz_write) else $error("high impedance bit not taken");

	property p_boost_off;
		!sel_reg && !(volt_reg[`UCO_VOLT_OTG_PIN_ENABLE] && otg_active) |=> !O_BOOST_ENABLE;
	endproperty
	a_boost_off: assert property (p_boost_off) else $error("boost on without request");

	property p_boost_sel;
		sel_reg && !hz_reg |=> O_BOOST_ENABLE;
	endproperty
	a_boost_sel: assert property (p_boost_sel) else $error("boost select ignored");

	property p_hz_blocks;
		hz_reg |=> !O_BOOST_ENABLE;
	endproperty
	a_hz_blocks: assert property (p_hz_blocks) else $error("boost while high impedance");

	property p_timer_set;
		I_FIFTEEN_MINUTE_TIMER_EXPIRED |=> O_USB_CHARGE_DISABLE;
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer expiry lost");

	property p_code_map;
		##1 O_USB_FLOAT_VOLTAGE_CODE == ($past(code_field) > `UCO_FLOAT_CODE_MAX ? `UCO_FLOAT_CODE_MAX
			: $past(code_field));
	endproperty
	a_code_map: assert property (p_code_map) else $error("float code mismatch");

	property p_volt_reset;
		$past(I_RST) |-> volt_reg == `UCO_VOLT_RST && O_USB_FLOAT_VOLTAGE_CODE == 6'h02;
	endproperty
	a_volt_reset: assert property (p_volt_reset) else $error("voltage register reset wrong");

	property p_otg_low;
		!volt_reg[`UCO_VOLT_OTG_POL] && volt_reg[`UCO_VOLT_OTG_PIN_ENABLE] && !otg_f_reg && !hz_reg |=> O_BOOST_ENABLE;
	endproperty
	a_otg_low: assert property (p_otg_low) else $error("active low pin ignored");

	property p_otg_high;
		volt_reg[`UCO_VOLT_OTG_POL] && volt_reg[`UCO_VOLT_OTG_PIN_ENABLE] && otg_f_reg && !hz_reg |=> O_BOOST_ENABLE;
	endproperty
	a_otg_high: assert property (p_otg_high) else $error("active high pin ignored");

	property p_ctrl_reset;
		$past(I_RST) |-> !hz_reg && !sel_reg && !cd_reg && !O_BOOST_ENABLE;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control register reset wrong");

	property p_sel_write;
		bus.wr_stb && bus.addr == `UCO_REG_CTRL |=> sel_reg == $past(bus.wdata[`UCO_CTRL_BOOST_SEL]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("boost select bit not taken");

	property p_cd_write;
		bus.wr_stb && bus.addr == `UCO_REG_CTRL && !I_FIFTEEN_MINUTE_TIMER_EXPIRED
			|=> O_USB_CHARGE_DISABLE == $past(bus.wdata[`UCO_CTRL_CHG_DIS]);
	endproperty
	a_cd_write: assert property (p_cd_write) else $error("charge disable bit not taken");

	// only a write or the timer may move the disable bit
	property p_cd_hold;
		!(bus.wr_stb && bus.addr == `UCO_REG_CTRL) && !I_FIFTEEN_MINUTE_TIMER_EXPIRED |=> $stable(cd_reg);
	endproperty
	a_cd_hold: assert property (p_cd_hold) else $error("charge disable changed unprompted");

	property p_volt_write;
		bus.wr_stb && bus.addr == `UCO_REG_VOLT |=> volt_reg == $past(bus.wdata);
	endproperty
	a_volt_write: assert property (p_volt_write) else $error("voltage register write lost");

	property p_volt_hold;
		!(bus.wr_stb && bus.addr == `UCO_REG_VOLT) |=> $stable(volt_reg);
	endproperty
	a_volt_hold: assert property (p_volt_hold) else $error("voltage register changed unprompted");

	property p_code_top;
		O_USB_FLOAT_VOLTAGE_CODE <= `UCO_FLOAT_CODE_MAX;
	endproperty
	a_code_top: assert property (p_code_top) else $error("float code above scale");

	c_otg_boost: cover property (!sel_reg && O_BOOST_ENABLE);
	c_timer: cover property (I_FIFTEEN_MINUTE_TIMER_EXPIRED && !cd_reg);
	c_volt_write: cover property (bus.wr_stb && bus.addr == `UCO_REG_VOLT);
	c_hz_otg: cover property (hz_reg && volt_reg[`UCO_VOLT_OTG_PIN_ENABLE] && otg_active);
endmodule
`default_nettype wire

// *** logic/uco_defines.svh ***
`ifndef UCO_DEFINES_SVH
`define UCO_DEFINES_SVH

// ********************************
// register map
// ********************************
`define UCO_REG_CTRL        8'h01
`define UCO_REG_VOLT        8'h02
`define UCO_READ_UNMAPPED   8'h00

// ********************************
// field positions
// ********************************
`define UCO_CTRL_CHG_DIS    2
`define UCO_CTRL_HIGH_Z     1
`define UCO_CTRL_BOOST_SEL  0
`define UCO_VOLT_CODE_HI    7
`define UCO_VOLT_CODE_LO    2
`define UCO_VOLT_OTG_POL    1
`define UCO_VOLT_OTG_PIN_ENABLE     0

// ********************************
// reset values
// ********************************
`define UCO_CTRL_RST        1'h0
`define UCO_VOLT_RST        8'h0A

// ********************************
// float voltage scale, millivolts
// ********************************
`define UCO_FLOAT_BASE_MV   3500
`define UCO_FLOAT_STEP_MV   20
`define UCO_FLOAT_MAX_MV    4440
`define UCO_FLOAT_CODE_MAX  6'((`UCO_FLOAT_MAX_MV - `UCO_FLOAT_BASE_MV) / `UCO_FLOAT_STEP_MV)

// ********************************
// serial bus
// ********************************
`define UCO_SLAVE_ADDR      7'h6B
`define UCO_BITS_PER_BYTE   4'h8

`endif

// *** logic/uco_i2c_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uco_defines.svh"
module uco_i2c_slave
	import uco_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output var  logic o_sda_oe,
	uco_reg_if.eng    bus
);
	// ********************************
	// pin synchronisers and filter
	// ********************************
	logic [2:0] scl_sync_reg, scl_sync_next;
	logic [2:0] sda_sync_reg, sda_sync_next;
	logic       scl_f_reg, scl_f_next, scl_d_reg;
	logic       sda_f_reg, sda_f_next, sda_d_reg;
	logic       rise, fall, start, stop;

	always_comb begin
		scl_sync_next = {scl_sync_reg[1:0], i_scl};
		sda_sync_next = {sda_sync_reg[1:0], i_sda};
		// a change counts only once stages two and three agree
		scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
		sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg    <= 1'b1;
			sda_f_reg    <= 1'b1;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_f_reg    <= scl_f_next;
			sda_f_reg    <= sda_f_next;
			scl_d_reg    <= scl_f_reg;
			sda_d_reg    <= sda_f_reg;
		end
	end

	assign rise  = scl_f_reg & ~scl_d_reg;
	assign fall  = ~scl_f_reg & scl_d_reg;
	assign start = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
	assign stop  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

	// ********************************
	// byte engine
	// ********************************
	uco_i2c_state_e state_reg, state_next;
	logic [3:0]     cnt_reg, cnt_next;
	logic [7:0]     sh_reg, sh_next;
	logic [7:0]     ptr_reg, ptr_next;
	logic [7:0]     wdata_reg, wdata_next;
	logic           oe_reg, oe_next;
	logic           wr_reg, wr_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		ptr_next   = ptr_reg;
		wdata_next = wdata_reg;
		oe_next    = oe_reg;
		wr_next    = 1'b0;
		if (start) begin
			state_next = UCO_ST_ADDR;
			cnt_next   = 4'h0;
			oe_next    = 1'b0;
		end else if (stop) begin
			state_next = UCO_ST_IDLE;
			oe_next    = 1'b0;
		end else begin
			case (state_reg)
				UCO_ST_ADDR, UCO_ST_PTR, UCO_ST_WR: begin
					if (rise && cnt_reg != `UCO_BITS_PER_BYTE) begin
						sh_next  = {sh_reg[6:0], sda_f_reg};
						cnt_next = cnt_reg + 4'h1;
					end else if (fall && cnt_reg == `UCO_BITS_PER_BYTE) begin
						cnt_next = 4'h0;
						oe_next  = 1'b1;
						if (state_reg == UCO_ST_ADDR) begin
							// foreign address: stay silent until the next start
							if (sh_reg[7:1] == `UCO_SLAVE_ADDR) begin
								state_next = UCO_ST_AACK;
							end else begin
								state_next = UCO_ST_IDLE;
								oe_next    = 1'b0;
							end
						end else if (state_reg == UCO_ST_PTR) begin
							ptr_next   = sh_reg;
							state_next = UCO_ST_PACK;
						end else begin
							wr_next    = 1'b1;
							wdata_next = sh_reg;
							state_next = UCO_ST_WACK;
						end
					end
				end
				UCO_ST_AACK, UCO_ST_PACK, UCO_ST_WACK: begin
					if (fall) begin
						oe_next  = 1'b0;
						cnt_next = 4'h0;
						if (state_reg == UCO_ST_AACK && sh_reg[0]) begin
							state_next = UCO_ST_RD;
							sh_next    = bus.rdata;
							oe_next    = ~bus.rdata[7];
						end else if (state_reg == UCO_ST_AACK) begin
							state_next = UCO_ST_PTR;
						end else begin
							if (state_reg == UCO_ST_WACK) begin
								ptr_next = ptr_reg + 8'h01;
							end
							state_next = UCO_ST_WR;
						end
					end
				end
				UCO_ST_RD: begin
					if (rise) begin
						cnt_next = cnt_reg + 4'h1;
					end else if (fall && cnt_reg == `UCO_BITS_PER_BYTE) begin
						oe_next    = 1'b0;
						cnt_next   = 4'h0;
						ptr_next   = ptr_reg + 8'h01;
						state_next = UCO_ST_RACK;
					end else if (fall) begin
						sh_next = {sh_reg[6:0], 1'b0};
						oe_next = ~sh_reg[6];
					end
				end
				UCO_ST_RACK: begin
					// a nack ends the read; the master then sends stop
					if (rise && sda_f_reg) begin
						state_next = UCO_ST_IDLE;
					end else if (rise) begin
						cnt_next = 4'h1;
					end else if (fall && cnt_reg == 4'h1) begin
						state_next = UCO_ST_RD;
						cnt_next   = 4'h0;
						sh_next    = bus.rdata;
						oe_next    = ~bus.rdata[7];
					end
				end
				default: begin
					state_next = UCO_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= UCO_ST_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			ptr_reg   <= 8'h00;
			wdata_reg <= 8'h00;
			oe_reg    <= 1'b0;
			wr_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			ptr_reg   <= ptr_next;
			wdata_reg <= wdata_next;
			oe_reg    <= oe_next;
			wr_reg    <= wr_next;
		end
	end

	assign o_sda_oe   = oe_reg;
	assign bus.wr_stb = wr_reg;
	assign bus.addr   = ptr_reg;
	assign bus.wdata  = wdata_reg;

	// ********************************
	// checks
	// ********************************
	property p_addr_reject;
		@(posedge i_clk) disable iff (i_rst)
		(state_reg == UCO_ST_ADDR && fall && !start && !stop && cnt_reg == `UCO_BITS_PER_BYTE
			&& sh_reg[7:1] != `UCO_SLAVE_ADDR) |=> (state_reg == UCO_ST_IDLE && !o_sda_oe);
	endproperty
	a_addr_reject: assert property (p_addr_reject) else $error("foreign address acknowledged");

	property p_addr_ack;
		@(posedge i_clk) disable iff (i_rst)
		(state_reg == UCO_ST_AACK) |-> (o_sda_oe && sh_reg[7:1] == `UCO_SLAVE_ADDR);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address ack without match");

	property p_cov_read;
		@(posedge i_clk) disable iff (i_rst)
		state_reg == UCO_ST_RACK;
	endproperty
	c_cov_read: cover property (p_cov_read);
endmodule
`default_nettype wire

// *** logic/uco_pkg.sv ***
`default_nettype none
package uco_pkg;
	// gray codes along address, pointer, write path
	typedef enum logic [3:0] {
		UCO_ST_IDLE = 4'h0,
		UCO_ST_ADDR = 4'h1,
		UCO_ST_AACK = 4'h3,
		UCO_ST_PTR  = 4'h2,
		UCO_ST_PACK = 4'h6,
		UCO_ST_WR   = 4'h7,
		UCO_ST_WACK = 4'h5,
		UCO_ST_RD   = 4'hC,
		UCO_ST_RACK = 4'hD
	} uco_i2c_state_e;
endpackage
`default_nettype wire

// *** logic/uco_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface uco_reg_if;
	logic       wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport eng (
		output wr_stb,
		output addr,
		output wdata,
		input  rdata
	);
	modport regs (
		input  wr_stb,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uco_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
	// ********************************
	// signals and instances
	// ********************************
	localparam int LIMIT = 95000;
	logic       clk;
	logic       rst;
	logic       scl;
	logic       sda_host;
	logic       sda_line;
	logic       sda_oe;
	logic       sda_out;
	logic       otg_pin;
	logic       timer_pulse;
	logic       hz;
	logic       chg_dis;
	logic       boost;
	logic [5:0] code;
	logic [15:0] rdat;
	logic [7:0] ctrl;
	logic [7:0] volt;
	logic [5:0] corners [4];
	int         err_total;
	int         comparisons;
	int         cycles;

	// pull-up wins unless either side pulls low
	assign sda_line = sda_host & ~(sda_oe & ~sda_out);

	uco_charger_otg_regs i_dut (
		.I_CLK                          (clk),
		.I_RST                          (rst),
		.I_SCL                          (scl),
		.I_SDA                          (sda_line),
		.O_SDA_OUT                      (sda_out),
		.O_SDA_OE                       (sda_oe),
		.I_OTG_PIN                      (otg_pin),
		.I_FIFTEEN_MINUTE_TIMER_EXPIRED (timer_pulse),
		.O_USB_HIGH_IMPEDANCE           (hz),
		.O_USB_CHARGE_DISABLE           (chg_dis),
		.O_BOOST_ENABLE                 (boost),
		.O_USB_FLOAT_VOLTAGE_CODE       (code)
	);

	uco_host_model i_host (
		.i_clk (clk),
		.i_sda (sda_line),
		.o_scl (scl),
		.o_sda (sda_host)
	);

	// ********************************
	// expectations
	// ********************************
	function automatic logic exp_boost(input logic [7:0] c, input logic [7:0] v, input logic p);
		return !c[1] & (c[0] | (v[0] & (v[1] ? p : !p)));
	endfunction

	// codes above the 4.44 V step saturate
	function automatic logic [5:0] exp_code(input logic [7:0] v);
		int top;
		top = (`UCO_FLOAT_MAX_MV - `UCO_FLOAT_BASE_MV) / `UCO_FLOAT_STEP_MV;
		return (int'(v[7:2]) > top) ? 6'(top) : v[7:2];
	endfunction

	task automatic wrap_up();
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			err_total++;
			wrap_up();
		end
	end

	// ********************************
	// main sequence
	// ********************************
	initial begin
		rst         = 1'b1;
		otg_pin     = 1'b0;
		timer_pulse = 1'b0;
		err_total   = 0;
		comparisons = 0;
		corners     = '{6'h00, 6'h2F, 6'h30, 6'h3F};
		void'($urandom(70));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		i_host.rd(8'h01, rdat);
		`CHK(rdat, 16'h000A)
		`CHK(code, 6'h02)
		`CHK(hz, 1'b0)
		`CHK(boost, 1'b0)
		`CHK(sda_out, 1'b0)
		i_host.probe(8'hD4);
		`CHK(i_host.ack_ok, 1'b0)
		// every mix of high-Z, select, polarity and pin enable, both pin levels
		for (int k = 0; k < 16; k++) begin
			ctrl = {5'h00, 1'($urandom), k[0], k[1]};
			volt = {(k < 4) ? corners[k] : 6'($urandom), k[2], k[3]};
			i_host.wr(8'h01, {ctrl, volt});
			repeat (4) @(negedge clk);
			`CHK(i_host.ack_ok, 1'b1)
			`CHK(hz, ctrl[1])
			`CHK(chg_dis, ctrl[2])
			`CHK(code, exp_code(volt))
			for (int p = 0; p < 2; p++) begin
				otg_pin = 1'(p);
				repeat (12) @(negedge clk);
				`CHK(boost, exp_boost(ctrl, volt, otg_pin))
			end
			i_host.rd(8'h01, rdat);
			`CHK(rdat, {ctrl, volt})
		end
		// mid-run reset from the last mix: high-Z and select both set
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(code, 6'h02)
		`CHK(hz, 1'b0)
		`CHK(chg_dis, 1'b0)
		`CHK(boost, 1'b0)
		i_host.wr(8'h01, 16'h000A);
		timer_pulse = 1'b1;
		@(negedge clk);
		timer_pulse = 1'b0;
		@(negedge clk);
		`CHK(chg_dis, 1'b1)
		i_host.rd(8'h01, rdat);
		`CHK(rdat, 16'h040A)
		i_host.wr(8'h01, 16'h000A);
		repeat (4) @(negedge clk);
		`CHK(chg_dis, 1'b0)
		i_host.rd(8'h05, rdat);
		`CHK(rdat, 16'h0000)
		wrap_up();
	end
endmodule
`default_nettype wire

// *** sim/uco_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module uco_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda
);
	// ********************************
	// serial bus master, open drain
	// ********************************
	// 20 clocks per high/low phase; the slave filter passes any level held for two clocks
	localparam int HALF = 20;
	logic ack_ok;

	initial begin
		o_scl  = 1'b1;
		o_sda  = 1'b1;
		ack_ok = 1'b1;
	end

	task automatic half();
		repeat (HALF) @(negedge i_clk);
	endtask

	// also serves as repeated start from a low clock phase
	task automatic start();
		o_sda = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		o_sda = 1'b0;
		half();
		o_scl = 1'b0;
	endtask

	task automatic stop();
		o_sda = 1'b0;
		half();
		o_scl = 1'b1;
		half();
		o_sda = 1'b1;
		half();
	endtask

	// sample at end of high phase, slave ack holds past the fall
	task automatic clk_bit(input logic b, output logic s);
		o_sda = b;
		half();
		o_scl = 1'b1;
		half();
		s     = i_sda;
		o_scl = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		if (s) begin
			ack_ok = 1'b0;
		end
	endtask

	task automatic recv_byte(output logic [7:0] d, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(last, s);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
		ack_ok = 1'b1;
		start();
		send_byte(8'hD6);
		send_byte(ptr);
		send_byte(d[15:8]);
		send_byte(d[7:0]);
		stop();
	endtask

	task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
		ack_ok = 1'b1;
		start();
		send_byte(8'hD6);
		send_byte(ptr);
		start();
		send_byte(8'hD7);
		recv_byte(d[15:8], 1'b0);
		recv_byte(d[7:0], 1'b1);
		stop();
	endtask

	task automatic probe(input logic [7:0] addr);
		ack_ok = 1'b1;
		start();
		send_byte(addr);
		stop();
	endtask
endmodule
`default_nettype wire
